/* rtl/nbi_host.v */
// Notes on behaviour
// (R1) Command cycle: CLE high, ALE low, WE rises.
// (R2) Address cycle: ALE high, CLE low, WE rises.
// (R3) Data write: CLE, ALE low, WE rises.
// (R4) Busy or unselected die discards data input.
// (R5) Busy die ignores commands except status, reset.
// (R6) Upper byte zero during x16 command cycles.
// (R7) Commands, addresses only on low byte.
// (R8) Out-of-space address bits driven low.
// (R9) x8 four address cycles: column, page, block.
// (R10) x8: column bit 11 set clears bits 10..6.
// (R11) x16: column bit 10 set clears 9..5.
// (R12) Upper byte low during x16 address cycles.
// (R13) Order: command, addresses, then data cycles.
// (R14) Chip select high while idle gives standby.
// (R15) Operation continues with chip select high.
// (R16) 1024 blocks of 64 pages each.
// (R17) Data and cache registers act per mode.
// (R18) Pages read/programmed, blocks erased whole.
// (R19) Reset command first after power-on.
// (R20) Write protect low blocks program, erase.
// (R21) Each die runs, reports status independently.
// (R22) Status byte: done, pass/fail, protect.
// (R23) All dies share one chip select.
// (R24) Read data valid on falling read strobe.
// (R25) Ready/busy low while any die busy.
`timescale 1ns/1ps
`include "nbi_defs.vh"
module nbi_host #(
  parameter WIDE = 0
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        arst_n,
  input  wire        clk_en,
  // Request port.
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_op,
  input  wire [7:0]  req_cmd,
  input  wire [`NBI_COL_W-1:0]   req_col,
  input  wire [`NBI_PAGE_W-1:0]  req_page,
  input  wire [`NBI_BLOCK_W-1:0] req_block,
  input  wire [15:0] req_wdata,
  input  wire        req_last,
  input  wire        wp_allow,
  // Answer port.
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  output reg         init_done_q,
  output wire        target_busy,
  output reg         cmd_refused_q,
  // Flash pins.
  output reg         chip_sel_n_q,
  output reg         cmd_latch_q,
  output reg         addr_latch_q,
  output reg         write_strobe_n_q,
  output reg         read_strobe_n_q,
  output reg         write_prot_n_q,
  output reg  [15:0] io_out_q,
  output reg         io_oe_q,
  input  wire [15:0] io_in,
  input  wire        ready_busy_n
);
  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  reg [2:0] rb_sync_q;
  reg       rb_q;
  reg [15:0] io_s1_q;
  reg [15:0] io_s2_q;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rb_sync_q <= 3'h0;
      rb_q      <= 1'b0;
      io_s1_q   <= 16'h0000;
      io_s2_q   <= 16'h0000;
    end else if (clk_en) begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_n};
      if (rb_sync_q[1] == rb_sync_q[2])
        rb_q <= rb_sync_q[2];
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end
  // The target reports busy whenever any die pulls the shared line low.
  assign target_busy = !rb_q; // see (R25) (R21) (R23)

  // ----------------------------------------------------------------
  // Cycle sequencer.
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_LOW  = 5'h02;
  localparam [4:0] S_HIGH = 5'h04;
  localparam [4:0] S_SAMP = 5'h08;
  localparam [4:0] S_END  = 5'h10;
  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [1:0] op_q;
  reg [1:0] acyc_q;
  reg       last_q;
  reg [7:0] acol_hi_q;
  reg [7:0] a_byte;
  reg [`NBI_COL_W-1:0] col_clean;
  reg       cmd_ok;
  wire      go = req_valid && state_q == S_IDLE && clk_en;
  assign req_ready = state_q == S_IDLE;

  // Clean the column so that forbidden bits are zero.
  always @* begin
    col_clean = req_col;
    if (WIDE != 0) begin
      col_clean[11] = 1'b0; // see (R8)
      if (req_col[10])
        col_clean[9:5] = 5'h00; // see (R11)
    end else if (req_col[11]) begin
      col_clean[10:6] = 5'h00; // see (R10)
    end
  end

  // One byte per address cycle; the unused upper nibble stays low.
  always @* begin
    case (acyc_q)
      2'h0: a_byte = col_clean[7:0];
      2'h1: a_byte = acol_hi_q; // see (R9) (R11)
      2'h2: a_byte = {req_block[1:0], req_page}; // see (R9) (R16)
      default: a_byte = req_block[9:2];
    endcase
  end

  // Before init only reset is issued; while busy only status and reset pass.
  always @* begin
    cmd_ok = 1'b1;
    if (req_op == `NBI_OP_CMD) begin
      if (!init_done_q && req_cmd != `NBI_CMD_RESET)
        cmd_ok = 1'b0; // see (R19)
      if (target_busy && req_cmd != `NBI_CMD_STATUS && req_cmd != `NBI_CMD_RESET)
        cmd_ok = 1'b0; // see (R5)
    end else if (target_busy || !init_done_q) begin
      cmd_ok = 1'b0; // see (R4) (R24)
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q          <= S_IDLE;
      cnt_q            <= 4'h0;
      op_q             <= 2'h0;
      acyc_q           <= 2'h0;
      last_q           <= 1'b0;
      acol_hi_q        <= 8'h00;
      chip_sel_n_q     <= 1'b1;
      cmd_latch_q      <= 1'b0;
      addr_latch_q     <= 1'b0;
      write_strobe_n_q <= 1'b1;
      read_strobe_n_q  <= 1'b1;
      write_prot_n_q   <= 1'b0;
      io_out_q         <= 16'h0000;
      io_oe_q          <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_rdata        <= 16'h0000;
      init_done_q      <= 1'b0;
      cmd_refused_q    <= 1'b0;
    end else if (clk_en) begin
      rsp_valid     <= 1'b0;
      cmd_refused_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Write protect only changes between cycles, while the target is not busy.
          if (!target_busy)
            write_prot_n_q <= wp_allow; // see (R20)
          if (go && !cmd_ok) begin
            cmd_refused_q <= 1'b1;
          end else if (go) begin
            op_q   <= req_op;
            last_q <= req_last;
            cnt_q  <= 4'h0;
            chip_sel_n_q <= 1'b0;
            cmd_latch_q  <= req_op == `NBI_OP_CMD; // see (R1) (R13)
            addr_latch_q <= req_op == `NBI_OP_ADDR; // see (R2)
            io_oe_q      <= req_op != `NBI_OP_READ;
            if (req_op == `NBI_OP_CMD) begin
              io_out_q <= {8'h00, req_cmd}; // see (R6) (R7)
              acyc_q   <= 2'h0;
              if (req_cmd == `NBI_CMD_RESET)
                init_done_q <= 1'b1;
            end else if (req_op == `NBI_OP_ADDR) begin
              io_out_q <= {8'h00, a_byte}; // see (R12) (R7)
              if (acyc_q == 2'h0)
                acol_hi_q <= (WIDE != 0) ? {5'h00, col_clean[10:8]}
                                         : {4'h0, col_clean[11:8]};
              acyc_q <= acyc_q + 2'h1;
            end else if (req_op == `NBI_OP_WRITE) begin
              io_out_q <= (WIDE != 0) ? req_wdata : {8'h00, req_wdata[7:0]}; // see (R3)
            end
            if (req_op == `NBI_OP_READ)
              read_strobe_n_q <= 1'b0;
            else
              write_strobe_n_q <= 1'b0;
            state_q <= S_LOW;
          end
        end
        S_LOW: begin
          if (cnt_q == `NBI_STROBE_LOW_CYC - 1) begin
            cnt_q   <= 4'h0;
            state_q <= (op_q == `NBI_OP_READ) ? S_SAMP : S_HIGH;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_SAMP: begin
          // Sample a little after the strobe so the synchronised bus settles.
          if (cnt_q == 4'h2) begin
            rsp_rdata <= (WIDE != 0) ? io_s2_q : {8'h00, io_s2_q[7:0]}; // see (R24)
            rsp_valid <= 1'b1;
            read_strobe_n_q <= 1'b1;
            cnt_q   <= 4'h0;
            state_q <= S_HIGH;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_HIGH: begin
          write_strobe_n_q <= 1'b1;
          read_strobe_n_q  <= 1'b1;
          if (cnt_q == `NBI_STROBE_HIGH_CYC - 1) begin
            cnt_q   <= 4'h0;
            state_q <= S_END;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        S_END: begin
          cmd_latch_q  <= 1'b0;
          addr_latch_q <= 1'b0;
          io_oe_q      <= 1'b0;
          if (op_q != `NBI_OP_READ)
            rsp_valid <= 1'b1;
          // Release chip select at sequence end; the die keeps working.
          if (last_q)
            chip_sel_n_q <= 1'b1; // see (R14) (R15)
          if (op_q == `NBI_OP_CMD)
            acyc_q <= 2'h0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // Page/block granularity, status content and cache mode live in the die. see (R17) (R18) (R22)
endmodule // nbi_host

/* rtl/nbi_defs.vh */
`ifndef NBI_DEFS_VH
`define NBI_DEFS_VH
// Host-side timing, in nanoseconds, and derived cycle counts at 200 MHz.
`define NBI_CLK_PERIOD_NS  5
`define NBI_TWC_NS         25
`define NBI_STROBE_LOW_CYC  ((`NBI_TWC_NS / 2 + `NBI_CLK_PERIOD_NS - 1) / `NBI_CLK_PERIOD_NS)
`define NBI_STROBE_HIGH_CYC ((`NBI_TWC_NS / 2 + `NBI_CLK_PERIOD_NS - 1) / `NBI_CLK_PERIOD_NS)
// Command codes.
`define NBI_CMD_RESET      8'hFF
`define NBI_CMD_STATUS     8'h70
// Address cycle layout.
`define NBI_ADDR_CYCLES    4
`define NBI_COL_W          12
`define NBI_PAGE_W         6
`define NBI_BLOCK_W        10
// Operation kinds on the request port.
`define NBI_OP_CMD         2'h0
`define NBI_OP_ADDR        2'h1
`define NBI_OP_WRITE       2'h2
`define NBI_OP_READ        2'h3
`endif

/* bench/nbi_host_assertions.sv */
`timescale 1ns/1ps
`include "nbi_defs.vh"
module nbi_host_checker (
  // Clock, reset and request side.
  input wire logic        clock, arst_n, clk_en, req_valid, req_ready,
  input wire logic [1:0]  req_op,
  input wire logic [7:0]  req_cmd,
  input wire logic        init_done_q, target_busy, cmd_refused_q,
  // Flash pins.
  input wire logic        chip_sel_n_q, cmd_latch_q, addr_latch_q,
  input wire logic        write_strobe_n_q, read_strobe_n_q, io_oe_q,
  input wire logic [15:0] io_out_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire take = clk_en && req_valid && req_ready;
  wire free = req_op == `NBI_OP_CMD && (req_cmd == `NBI_CMD_STATUS || req_cmd == `NBI_CMD_RESET);
  cmd_upper_a: assert property (cmd_latch_q && !chip_sel_n_q |-> io_out_q[15:8] == 8'h00)
    else $error("Upper byte set in a command cycle.");
  addr_upper_a: assert property (addr_latch_q && !chip_sel_n_q |-> io_out_q[15:8] == 8'h00)
    else $error("Upper byte set in an address cycle.");
  latch_excl_a: assert property (!write_strobe_n_q |-> !(cmd_latch_q && addr_latch_q))
    else $error("Both latches high under a write strobe.");
  strobe_excl_a: assert property (!write_strobe_n_q |-> read_strobe_n_q && !chip_sel_n_q)
    else $error("Write strobe low with read strobe or no select.");
  write_drive_a: assert property ($fell(write_strobe_n_q) |-> io_oe_q)
    else $error("Bus not driven under a write strobe.");
  write_hold_a: assert property (!write_strobe_n_q ##1 !write_strobe_n_q |-> $stable(io_out_q))
    else $error("Bus changed under a write strobe.");
  strobe_len_a: assert property ($fell(write_strobe_n_q) |-> !write_strobe_n_q[*2] ##[1:4] write_strobe_n_q)
    else $error("Write strobe pulse out of range.");
  read_float_a: assert property (!read_strobe_n_q |-> !io_oe_q)
    else $error("Host drives the bus during a read.");
  refuse_busy_a: assert property (take && init_done_q && target_busy && !free |=> cmd_refused_q)
    else $error("Request taken while target busy.");
  init_first_a: assert property (take && !init_done_q && !free |=> cmd_refused_q && write_strobe_n_q)
    else $error("Request before reset command.");
endmodule // nbi_host_checker
bind nbi_host nbi_host_checker i_nbi_host_checker (.*);

/* bench/nbi_flash_model.sv */
`timescale 1ns/1ps
module nbi_flash_model (
  // Pins from the host.
  input wire logic        chip_sel_n_q, cmd_latch_q, addr_latch_q,
  input wire logic        write_strobe_n_q, read_strobe_n_q,
  input wire logic [15:0] io_out_q,
  // Answers to the host.
  output logic [15:0]     io_in,
  output logic            ready_busy_n
);
  logic [7:0] cmd_q, addr_b [4], cache [64];
  int ai = 0, wi = 0, ri = 0;
  wire sel = !chip_sel_n_q && read_strobe_n_q;
  wire free = io_out_q[7:0] inside {8'h70, 8'hFF};
  initial io_in = 16'h5A5A;
  initial ready_busy_n = 1'b1;
  always @(posedge write_strobe_n_q) begin
    if (sel && cmd_latch_q && !addr_latch_q && (ready_busy_n || free)) begin
      cmd_q = io_out_q[7:0];
      ai = 0;
      ri = 0;
      if (cmd_q == 8'hFF) begin
        ready_busy_n = 1'b0;
        ready_busy_n <= #400 1'b1;
      end
    end else if (sel && addr_latch_q && !cmd_latch_q) begin
      addr_b[ai % 4] = io_out_q[7:0];
      ai++;
      wi = 0;
    end else if (sel && !cmd_latch_q && !addr_latch_q && ready_busy_n) begin
      cache[wi % 64] = io_out_q[7:0];
      wi++;
    end
  end
  always @(negedge read_strobe_n_q) begin
    if (!chip_sel_n_q && !cmd_latch_q && !addr_latch_q && write_strobe_n_q && ready_busy_n) begin
      io_in = {8'h00, cache[ri % 64]};
      ri++;
    end
  end
  // A released bus shows the inverse of its last value.
  always @(posedge read_strobe_n_q or posedge chip_sel_n_q) io_in = ~io_in;
endmodule // nbi_flash_model

/* bench/tb.sv */
`timescale 1ns/1ps
`include "nbi_defs.vh"
module tb;
  logic clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, wp_allow = 1'b1, req_valid = 1'b0;
  logic req_last = 1'b0, refd, rsp_valid, init_done_q, cmd_refused_q, chip_sel_n_q;
  logic cmd_latch_q, addr_latch_q, write_strobe_n_q, read_strobe_n_q, write_prot_n_q;
  logic io_oe_q, ready_busy_n, req_ready, target_busy;
  logic [1:0] req_op = 2'h0;
  logic [7:0] req_cmd = 8'h00, e [4], q [$];
  logic [11:0] req_col = 12'h000, c;
  logic [5:0] req_page = 6'h00;
  logic [9:0] req_block = 10'h000;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, io_out_q, io_in, rd;
  int error_cnt = 0, samples_checked = 0;
  always #2.5 clock = ~clock;
  nbi_host i_nbi_host (.*);
  nbi_flash_model i_nbi_flash_model (.*);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [1:0] op, input logic [7:0] cm, input logic [15:0] d,
                     input logic l);
    int n;
    n = 0;
    req_op <= op;
    req_cmd <= cm;
    req_wdata <= d;
    req_last <= l;
    req_valid <= 1'b1;
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    while (rsp_valid !== 1'b1 && cmd_refused_q !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    refd = cmd_refused_q;
    rd = rsp_rdata;
    check(16'(n < 40), 16'h1);
    @(posedge clock);
  endtask
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 200 && target_busy !== v; n++) @(posedge clock);
  endtask
  task automatic conclude;
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    void'($urandom(32'h33f8));
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    req(`NBI_OP_ADDR, 8'h00, 16'h0000, 1'b0);
    check(16'(refd), 16'h1);
    req(`NBI_OP_CMD, `NBI_CMD_RESET, 16'h0000, 1'b1);
    check(16'(refd), 16'h0);
    wait_busy(1'b1);
    check(16'(write_prot_n_q), 16'h1);
    req(`NBI_OP_CMD, 8'h80, 16'h0000, 1'b1);
    check(16'(refd), 16'h1);
    req(`NBI_OP_CMD, `NBI_CMD_STATUS, 16'h0000, 1'b1);
    check({8'h00, i_nbi_flash_model.cmd_q}, 16'h0070);
    wait_busy(1'b0);
    $display("Test init done");
    for (int i = 0; i < 3; i++) begin
      req_col <= 12'($urandom) | (i == 0 ? 12'h800 : 12'h000);
      req_page <= 6'($urandom);
      req_block <= 10'($urandom);
      req(`NBI_OP_CMD, 8'h80, 16'h0000, 1'b0);
      repeat (4) req(`NBI_OP_ADDR, 8'h00, 16'h0000, 1'b0);
      c = req_col;
      if (c[11]) c[10:6] = 5'h00;
      e = '{c[7:0], {4'h0, c[11:8]}, {req_block[1:0], req_page}, req_block[9:2]};
      for (int k = 0; k < 4; k++) check({8'h00, i_nbi_flash_model.addr_b[k]}, {8'h00, e[k]});
      for (int k = 0; k < 4; k++) begin
        q.push_back(8'($urandom));
        req(`NBI_OP_WRITE, 8'h00, {8'h00, q[k]}, k == 3);
      end
      check(16'(chip_sel_n_q), 16'h1);
      req(`NBI_OP_CMD, 8'h00, 16'h0000, 1'b0);
      repeat (4) req(`NBI_OP_ADDR, 8'h00, 16'h0000, 1'b0);
      for (int k = 0; k < 4; k++) begin
        req(`NBI_OP_READ, 8'h00, 16'h0000, k == 3);
        check(rd, {8'h00, q.pop_front()});
      end
      $display("Test transfer %0d done", i);
    end
    conclude();
  end
endmodule // tb
